// ---- mgmt_master_model.sv ----
// Management master model issuing indexed register accesses
`timescale 1ns/1ps
module mgmt_master_model (
    input  wire logic        clk,
    input  wire logic        mgmt_done,
    input  wire logic        mgmt_access_pending,
    output logic             mgmt_req,
    output logic             mgmt_write,
    output logic      [4:0]  mgmt_index,
    output logic      [15:0] mgmt_wdata
);
    // Quiet bus at start
    initial begin
        mgmt_req   = 1'b0;
        mgmt_write = 1'b0;
        mgmt_index = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // One access; held until done or until 50 cycles have passed, so a slow answer is not cut short
    task automatic access(input logic wr, input logic [4:0] idx,
                          input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (mgmt_access_pending !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        mgmt_req   = 1'b1;
        mgmt_write = wr;
        mgmt_index = idx;
        mgmt_wdata = d;
        n = 0;
        // Done is looked at mid-cycle, where it has settled; the rising
        // edge after that samples it high, and only then is req dropped
        do begin
            @(negedge clk);
            n++;
        end while (mgmt_done !== 1'b1 && n < 50);
        @(negedge clk);
        mgmt_req   = 1'b0;
        // Released lines flip so stale data cannot pass for valid
        mgmt_index = ~idx;
        mgmt_wdata = ~d;
    endtask
endmodule

// ---- phy_mgmt_monitor.sv ----
// Port checker for the PHY management register set
`timescale 1ns/1ps
module phy_mgmt_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        mgmt_req,
    input wire logic        mgmt_write,
    input wire logic [4:0]  mgmt_index,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic        mgmt_done,
    input wire logic        mgmt_access_pending,
    input wire logic        an_speed_100,
    input wire logic        an_full_duplex,
    input wire logic        phy_soft_reset,
    input wire logic        loopback_en,
    input wire logic        speed_100,
    input wire logic        full_duplex,
    input wire logic        an_enable,
    input wire logic        power_down,
    input wire logic        an_restart,
    input wire logic        col_test_en,
    input wire logic        pause_sym_en,
    input wire logic        pause_asym_en
);
    logic take;
    logic take_ctl;
    logic take_sr;
    // Accepted requests; a soft reset write takes the long path
    assign take     = mgmt_req && !mgmt_access_pending;
    assign take_ctl = take && mgmt_write && mgmt_index == 5'h00;
    assign take_sr  = take_ctl && mgmt_wdata[15];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_access_answer: assert property (
        take && !take_sr |=> mgmt_done && mgmt_access_pending)
        else $error("access not answered one cycle after take");
    a_done_release: assert property (
        mgmt_done |=> !mgmt_done && !mgmt_access_pending)
        else $error("done or pending outlives the answer cycle");
    a_soft_reset_span: assert property (
        take_sr |=> (phy_soft_reset && !mgmt_done)[*5]
        ##1 (!phy_soft_reset && mgmt_done))
        else $error("soft reset span or its completion is wrong");
    a_restart_pulse: assert property (
        take_ctl && mgmt_wdata[9] && !mgmt_wdata[15]
        |=> an_restart ##1 !an_restart)
        else $error("restart write gave no single pulse");
    a_mode_bits: assert property (
        take_ctl && !mgmt_wdata[15] |=> loopback_en ==
        $past(mgmt_wdata[14]) && col_test_en == $past(mgmt_wdata[7]))
        else $error("loopback or collision test not taken from write");
    a_an_bits: assert property (
        take_ctl && !mgmt_wdata[15] |=> an_enable ==
        $past(mgmt_wdata[12]) && power_down == $past(mgmt_wdata[11]))
        else $error("autoneg enable or power down not taken from write");
    a_an_overrides: assert property (
        !$past(rst) && !phy_soft_reset && !$past(phy_soft_reset)
        && $past(an_enable) |-> speed_100 == $past(an_speed_100)
        && full_duplex == $past(an_full_duplex))
        else $error("negotiated mode not applied under autoneg");
    a_pause_single: assert property (
        !(pause_sym_en && pause_asym_en))
        else $error("both pause settings resolved at once");
    a_status_fixed: assert property (
        $past(take && !mgmt_write && mgmt_index == 5'h01) |-> mgmt_done
        && mgmt_rdata[15:11] == 5'h0F && mgmt_rdata[3] && mgmt_rdata[0])
        else $error("status ability bits wrong");
    a_unmapped_zero: assert property (
        $past(take && !mgmt_write && mgmt_index > 5'h05)
        |-> mgmt_rdata == 16'h0000)
        else $error("index outside the set did not read zero");
endmodule
bind phy_mgmt_register_set phy_mgmt_monitor mon (.*);

// ---- phy_mgmt_pkg.sv ----
// Constants, register layout and state codes of the PHY management set
package phy_mgmt_pkg;

    // Management port widths
    localparam int REG_IDX_W = 5;
    localparam int DATA_W    = 16;

    // Register indexes
    localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] IDX_BASIC_STATUS  = 5'h01;
    localparam logic [4:0] IDX_ID_HIGH       = 5'h02;
    localparam logic [4:0] IDX_ID_LOW        = 5'h03;
    localparam logic [4:0] IDX_ADVERTISE     = 5'h04;
    localparam logic [4:0] IDX_PARTNER       = 5'h05;

    // Basic control field positions
    localparam int CTL_SOFT_RESET   = 15;
    localparam int CTL_LOOPBACK     = 14;
    localparam int CTL_SPEED_100    = 13;
    localparam int CTL_AN_ENABLE    = 12;
    localparam int CTL_POWER_DOWN   = 11;
    localparam int CTL_AN_RESTART   = 9;
    localparam int CTL_FULL_DUPLEX  = 8;
    localparam int CTL_COL_TEST     = 7;

    // Basic control reset values
    localparam logic CTL_LOOPBACK_RST    = 1'b0;
    localparam logic CTL_SPEED_100_RST   = 1'b1;
    localparam logic CTL_AN_ENABLE_RST   = 1'b1;
    localparam logic CTL_POWER_DOWN_RST  = 1'b0;
    localparam logic CTL_FULL_DUPLEX_RST = 1'b0;
    localparam logic CTL_COL_TEST_RST    = 1'b0;

    // Basic status field positions and fixed ability bits
    localparam int          STS_AN_COMPLETE  = 5;
    localparam int          STS_REMOTE_FAULT = 4;
    localparam int          STS_LINK_UP      = 2;
    localparam int          STS_JABBER       = 1;
    localparam logic [15:0] STS_FIXED_BITS   = 16'h7809;

    // Advertisement layout
    localparam int          ADV_PAUSE_LO  = 10;
    localparam int          ADV_PAUSE_HI  = 11;
    localparam logic [15:0] ADV_RESET_VAL = 16'h01E1;
    localparam logic [15:0] ADV_WR_MASK   = 16'h2DFF;

    // Partner ability bits that are reported, the rest read zero
    localparam logic [15:0] LP_READ_MASK  = 16'hEDFF;
    localparam logic [15:0] LP_RESET_VAL  = 16'h0000;
    localparam int          LP_PAUSE_LO   = 10;
    localparam int          LP_PAUSE_HI   = 11;

    // Value returned for an index outside this set
    localparam logic [15:0] UNMAPPED_VAL  = 16'h0000;

    // Soft reset duration
    localparam int CLK_PERIOD_NS      = 20;
    localparam int SOFT_RESET_TIME_NS = 100;
    localparam int SOFT_RESET_CYCLES  =
        (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_CNT_W = 4;

    // Access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00,
        ST_ANSWER     = 2'b01,
        ST_SOFT_RESET = 2'b10
    } mgmt_state_t;

endpackage

// ---- phy_mgmt_register_set.sv ----
// Management register set of the 10/100 PHY, indexes 0 to 5
`timescale 1ns/1ps

module phy_mgmt_register_set #(
    parameter logic [15:0] ID_HIGH_RST = 16'h1234, // Arbitrary identity value
    parameter logic [15:0] ID_LOW_RST  = 16'h5678  // Arbitrary identity value
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Indexed management access
    input  wire logic        mgmt_req,
    input  wire logic        mgmt_write,
    input  wire logic [4:0]  mgmt_index,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_done,
    output logic             mgmt_access_pending,
    // Live conditions from the PHY core
    input  wire logic        link_up,
    input  wire logic        remote_fault_det,
    input  wire logic        jabber_det,
    input  wire logic        an_done,
    input  wire logic        an_speed_100,
    input  wire logic        an_full_duplex,
    input  wire logic        lp_word_valid,
    input  wire logic [15:0] lp_word,
    // Controls to the PHY core
    output logic             phy_soft_reset,
    output logic             loopback_en,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             an_enable,
    output logic             power_down,
    output logic             an_restart,
    output logic             col_test_en,
    output logic      [15:0] adv_word,
    output logic             pause_sym_en,
    output logic             pause_asym_en
);

    phy_mgmt_pkg::mgmt_state_t state_ff;
    phy_mgmt_pkg::mgmt_state_t nxt_state;

    logic [phy_mgmt_pkg::SR_CNT_W-1:0] sr_cnt_ff;
    logic        loopback_ff;
    logic        speed_sel_ff;
    logic        an_en_ff;
    logic        pwr_down_ff;
    logic        duplex_sel_ff;
    logic        col_test_ff;
    logic        an_restart_ff;
    logic        rf_latch_ff;
    logic        link_latch_ff;
    logic        jabber_latch_ff;
    logic [15:0] id_high_ff;
    logic [15:0] id_low_ff;
    logic [15:0] adv_ff;
    logic [15:0] lp_ff;
    logic [15:0] rdata_ff;
    logic        speed_ff;
    logic        duplex_ff;
    logic        pause_sym_ff;
    logic        pause_asym_ff;
    logic [15:0] ctl_word;
    logic [15:0] sts_word;
    logic [15:0] nxt_rdata;
    logic        take;
    logic        wr_take;
    logic        sts_read;
    logic        sr_start;
    logic        sr_active;

    // Index match of a taken access, read or write
    function automatic logic wr_hit(input logic [4:0] idx,
                                    input logic [4:0] target);
        wr_hit = (idx == target);
    endfunction

    // Pause option offered by both ends; shared by both resolutions
    function automatic logic both_offer(input logic [15:0] own,
                                        input logic [15:0] far,
                                        input int          pos);
        both_offer = own[pos] && far[pos];
    endfunction

    // A request is only taken while idle; others are ignored
    assign take      = mgmt_req && (state_ff == phy_mgmt_pkg::ST_IDLE);
    assign wr_take   = take && mgmt_write;
    assign sts_read  = take && !mgmt_write &&
                       wr_hit(mgmt_index, phy_mgmt_pkg::IDX_BASIC_STATUS);
    assign sr_start  = wr_take &&
                       wr_hit(mgmt_index, phy_mgmt_pkg::IDX_BASIC_CONTROL) &&
                       mgmt_wdata[phy_mgmt_pkg::CTL_SOFT_RESET];
    assign sr_active = (state_ff == phy_mgmt_pkg::ST_SOFT_RESET);

    // Sequencer: idle, one answer cycle, or soft reset hold
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            phy_mgmt_pkg::ST_IDLE: begin
                if (sr_start) begin
                    nxt_state = phy_mgmt_pkg::ST_SOFT_RESET;
                end else if (take) begin
                    nxt_state = phy_mgmt_pkg::ST_ANSWER;
                end
            end
            phy_mgmt_pkg::ST_SOFT_RESET: begin
                if (sr_cnt_ff == '0) begin
                    nxt_state = phy_mgmt_pkg::ST_ANSWER;
                end
            end
            default: begin
                nxt_state = phy_mgmt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= phy_mgmt_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Soft reset length counter
    always_ff @(posedge clk) begin
        if (rst) begin
            sr_cnt_ff <= '0;
        end else if (sr_start) begin
            sr_cnt_ff <= phy_mgmt_pkg::SR_CNT_W'(
                phy_mgmt_pkg::SOFT_RESET_CYCLES - 1);
        end else if (sr_active && sr_cnt_ff != '0) begin
            sr_cnt_ff <= sr_cnt_ff - 1'b1;
        end
    end

    // Control bits; a soft reset restores them since none is kept
    always_ff @(posedge clk) begin
        if (rst || sr_start) begin
            loopback_ff   <= phy_mgmt_pkg::CTL_LOOPBACK_RST;
            speed_sel_ff  <= phy_mgmt_pkg::CTL_SPEED_100_RST;
            an_en_ff      <= phy_mgmt_pkg::CTL_AN_ENABLE_RST;
            pwr_down_ff   <= phy_mgmt_pkg::CTL_POWER_DOWN_RST;
            duplex_sel_ff <= phy_mgmt_pkg::CTL_FULL_DUPLEX_RST;
            col_test_ff   <= phy_mgmt_pkg::CTL_COL_TEST_RST;
        end else if (wr_take &&
                     wr_hit(mgmt_index, phy_mgmt_pkg::IDX_BASIC_CONTROL)) begin
            loopback_ff   <= mgmt_wdata[phy_mgmt_pkg::CTL_LOOPBACK];
            speed_sel_ff  <= mgmt_wdata[phy_mgmt_pkg::CTL_SPEED_100];
            an_en_ff      <= mgmt_wdata[phy_mgmt_pkg::CTL_AN_ENABLE];
            pwr_down_ff   <= mgmt_wdata[phy_mgmt_pkg::CTL_POWER_DOWN];
            duplex_sel_ff <= mgmt_wdata[phy_mgmt_pkg::CTL_FULL_DUPLEX];
            col_test_ff   <= mgmt_wdata[phy_mgmt_pkg::CTL_COL_TEST];
        end
    end

    // Restart is taken by the core in the cycle after the write
    always_ff @(posedge clk) begin
        if (rst) begin
            an_restart_ff <= 1'b0;
        end else begin
            an_restart_ff <= wr_take && !sr_start &&
                wr_hit(mgmt_index, phy_mgmt_pkg::IDX_BASIC_CONTROL) &&
                mgmt_wdata[phy_mgmt_pkg::CTL_AN_RESTART];
        end
    end

    // Identifier registers, writable, restored by soft reset
    always_ff @(posedge clk) begin
        if (rst || sr_start) begin
            id_high_ff <= ID_HIGH_RST;
            id_low_ff  <= ID_LOW_RST;
        end else if (wr_take) begin
            if (wr_hit(mgmt_index, phy_mgmt_pkg::IDX_ID_HIGH)) begin
                id_high_ff <= mgmt_wdata;
            end else if (wr_hit(mgmt_index, phy_mgmt_pkg::IDX_ID_LOW)) begin
                id_low_ff <= mgmt_wdata;
            end
        end
    end

    // Advertisement; reserved bits stay zero
    always_ff @(posedge clk) begin
        if (rst || sr_start) begin
            adv_ff <= phy_mgmt_pkg::ADV_RESET_VAL;
        end else if (wr_take &&
                     wr_hit(mgmt_index, phy_mgmt_pkg::IDX_ADVERTISE)) begin
            adv_ff <= mgmt_wdata & phy_mgmt_pkg::ADV_WR_MASK;
        end
    end

    // Partner code word captured as the core receives it
    always_ff @(posedge clk) begin
        if (rst || sr_active) begin
            lp_ff <= phy_mgmt_pkg::LP_RESET_VAL;
        end else if (lp_word_valid) begin
            lp_ff <= lp_word & phy_mgmt_pkg::LP_READ_MASK;
        end
    end

    // Remote fault latches high; a read reloads live, so a new event wins
    always_ff @(posedge clk) begin
        if (rst || sr_active) begin
            rf_latch_ff <= 1'b0;
        end else if (sts_read) begin
            rf_latch_ff <= remote_fault_det;
        end else begin
            rf_latch_ff <= rf_latch_ff | remote_fault_det;
        end
    end

    // Link latches low so a short dropout stays visible until read
    always_ff @(posedge clk) begin
        if (rst || sr_active) begin
            link_latch_ff <= 1'b0;
        end else if (sts_read) begin
            link_latch_ff <= link_up;
        end else begin
            link_latch_ff <= link_latch_ff & link_up;
        end
    end

    // Jabber latches high in the same way as the remote fault
    always_ff @(posedge clk) begin
        if (rst || sr_active) begin
            jabber_latch_ff <= 1'b0;
        end else if (sts_read) begin
            jabber_latch_ff <= jabber_det;
        end else begin
            jabber_latch_ff <= jabber_latch_ff | jabber_det;
        end
    end

    // Register images for reads
    always_comb begin
        ctl_word = '0;
        ctl_word[phy_mgmt_pkg::CTL_SOFT_RESET]  = sr_active;
        ctl_word[phy_mgmt_pkg::CTL_LOOPBACK]    = loopback_ff;
        ctl_word[phy_mgmt_pkg::CTL_SPEED_100]   = speed_sel_ff;
        ctl_word[phy_mgmt_pkg::CTL_AN_ENABLE]   = an_en_ff;
        ctl_word[phy_mgmt_pkg::CTL_POWER_DOWN]  = pwr_down_ff;
        ctl_word[phy_mgmt_pkg::CTL_AN_RESTART]  = an_restart_ff;
        ctl_word[phy_mgmt_pkg::CTL_FULL_DUPLEX] = duplex_sel_ff;
        ctl_word[phy_mgmt_pkg::CTL_COL_TEST]    = col_test_ff;
        sts_word = phy_mgmt_pkg::STS_FIXED_BITS;
        sts_word[phy_mgmt_pkg::STS_AN_COMPLETE] = an_en_ff && an_done;
        sts_word[phy_mgmt_pkg::STS_REMOTE_FAULT] = rf_latch_ff;
        sts_word[phy_mgmt_pkg::STS_LINK_UP]      = link_latch_ff;
        sts_word[phy_mgmt_pkg::STS_JABBER]       = jabber_latch_ff;
    end

    // Index decode of read data; unused indexes read zero
    always_comb begin
        if (mgmt_index == phy_mgmt_pkg::IDX_BASIC_CONTROL) begin
            nxt_rdata = ctl_word;
        end else if (mgmt_index == phy_mgmt_pkg::IDX_BASIC_STATUS) begin
            nxt_rdata = sts_word;
        end else if (mgmt_index == phy_mgmt_pkg::IDX_ID_HIGH) begin
            nxt_rdata = id_high_ff;
        end else if (mgmt_index == phy_mgmt_pkg::IDX_ID_LOW) begin
            nxt_rdata = id_low_ff;
        end else if (mgmt_index == phy_mgmt_pkg::IDX_ADVERTISE) begin
            nxt_rdata = adv_ff;
        end else if (mgmt_index == phy_mgmt_pkg::IDX_PARTNER) begin
            nxt_rdata = lp_ff;
        end else begin
            nxt_rdata = phy_mgmt_pkg::UNMAPPED_VAL;
        end
    end

    // Read data held until the next taken read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (take && !mgmt_write) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Effective mode: negotiated result overrides manual selects
    always_ff @(posedge clk) begin
        if (rst) begin
            speed_ff  <= phy_mgmt_pkg::CTL_SPEED_100_RST;
            duplex_ff <= phy_mgmt_pkg::CTL_FULL_DUPLEX_RST;
        end else if (an_en_ff) begin
            speed_ff  <= an_speed_100;
            duplex_ff <= an_full_duplex;
        end else begin
            speed_ff  <= speed_sel_ff;
            duplex_ff <= duplex_sel_ff;
        end
    end

    // Pause resolution; symmetric preferred so both never come on
    always_ff @(posedge clk) begin
        if (rst || !(an_en_ff && an_done)) begin
            pause_sym_ff  <= 1'b0;
            pause_asym_ff <= 1'b0;
        end else begin
            pause_sym_ff  <= both_offer(adv_ff, lp_ff,
                                        phy_mgmt_pkg::ADV_PAUSE_LO);
            pause_asym_ff <= !both_offer(adv_ff, lp_ff,
                                         phy_mgmt_pkg::ADV_PAUSE_LO) &&
                             both_offer(adv_ff, lp_ff,
                                        phy_mgmt_pkg::ADV_PAUSE_HI);
        end
    end

    // Port drive; power-down relies on the master clearing AN first
    assign mgmt_rdata          = rdata_ff;
    assign mgmt_done           = (state_ff == phy_mgmt_pkg::ST_ANSWER);
    assign mgmt_access_pending = (state_ff != phy_mgmt_pkg::ST_IDLE);
    assign phy_soft_reset      = sr_active;
    assign loopback_en         = loopback_ff;
    assign speed_100           = speed_ff;
    assign full_duplex         = duplex_ff;
    assign an_enable           = an_en_ff;
    assign power_down          = pwr_down_ff;
    assign an_restart          = an_restart_ff;
    assign col_test_en         = col_test_ff;
    assign adv_word            = adv_ff;
    assign pause_sym_en        = pause_sym_ff;
    assign pause_asym_en       = pause_asym_ff;

endmodule

// ---- tb_top.sv ----
// Self-checking bench for the PHY management register set
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
    localparam logic [15:0] ID_H = 16'hA5C3; // Arbitrary identity value
    localparam logic [15:0] ID_L = 16'h3C5A; // Arbitrary identity value
    logic clk, rst, mgmt_req, mgmt_write, mgmt_done, mgmt_access_pending;
    logic link_up, remote_fault_det, jabber_det, an_done, lp_word_valid;
    logic an_speed_100, an_full_duplex, phy_soft_reset, loopback_en;
    logic speed_100, full_duplex, an_enable, power_down, an_restart;
    logic col_test_en, pause_sym_en, pause_asym_en;
    logic [4:0]  mgmt_index;
    logic [15:0] mgmt_wdata, mgmt_rdata, lp_word, adv_word, seed, d, e;
    logic [15:0] exp_q[$];
    bit          chk_q[$];
    bit          c;
    int          n_fail;
    int          check_count;

    phy_mgmt_register_set #(.ID_HIGH_RST(ID_H), .ID_LOW_RST(ID_L)) dut (.*);
    mgmt_master_model mm (.clk(clk), .mgmt_done(mgmt_done),
        .mgmt_access_pending(mgmt_access_pending), .mgmt_req(mgmt_req),
        .mgmt_write(mgmt_write), .mgmt_index(mgmt_index),
        .mgmt_wdata(mgmt_wdata));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Each access notes what its answer should hold
    task automatic rd(input logic [4:0] idx, input logic [15:0] x);
        exp_q.push_back(x);
        chk_q.push_back(1'b1);
        mm.access(1'b0, idx, 16'h0000);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] x);
        exp_q.push_back(16'h0000);
        chk_q.push_back(1'b0);
        mm.access(1'b1, idx, x);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Oldest note retired mid-cycle, while done stands settled
    always @(negedge clk) begin
        if (mgmt_done === 1'b1 && chk_q.size() > 0) begin
            c = chk_q.pop_front();
            e = exp_q.pop_front();
            if (c) `CHK(mgmt_rdata, e)
        end
    end
    // Cuts a hang short; the whole run needs well under this
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        {rst, link_up, remote_fault_det, jabber_det, an_done} = 5'h10;
        {an_speed_100, an_full_duplex, lp_word_valid} = 3'h0;
        lp_word = 16'h0000;
        n_fail = 0;
        check_count = 0;
        seed = 16'h6C3D;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        // Hardware reset values, unmapped indexes included
        rd(5'h00, 16'h3000);
        rd(5'h01, 16'h7809);
        rd(5'h02, ID_H);
        rd(5'h03, ID_L);
        rd(5'h04, 16'h01E1);
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0000);
        `CHK(adv_word, 16'h01E1)
        // Latched status bits, then their return to live values
        link_up = 1'b1;
        rd(5'h01, 16'h7809);
        rd(5'h01, 16'h780D);
        @(negedge clk);
        {link_up, remote_fault_det, jabber_det} = 3'h3;
        @(negedge clk);
        {link_up, remote_fault_det, jabber_det} = 3'h4;
        rd(5'h01, 16'h781B);
        rd(5'h01, 16'h780D);
        an_done = 1'b1;
        rd(5'h01, 16'h782D);
        // Random control writes, reserved bits included
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            {an_speed_100, an_full_duplex} = {seed[15], seed[9]};
            d = seed & 16'h7FFF;
            if (d[11]) d[12] = 1'b0;
            wr(5'h00, d);
            rd(5'h00, d & 16'h7980);
            `CHK(loopback_en, d[14])
            `CHK(col_test_en, d[7])
            `CHK(power_down, d[11])
            `CHK(speed_100, d[12] ? an_speed_100 : d[13])
            `CHK(full_duplex, d[12] ? an_full_duplex : d[8])
        end
        wr(5'h00, 16'h1200);
        rd(5'h00, 16'h1000);
        for (int p = 0; p < 4; p++) begin
            d = 16'h01E1 | (16'(p) << 10);
            wr(5'h04, d);
            rd(5'h04, d);
        end
        wr(5'h04, 16'hFFFF);
        rd(5'h04, 16'h2DFF);
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F, 16'h0000);
        // Partner word, then both pause options on both sides, then only the asymmetric option on this side
        seed = lfsr(seed);
        lp_word = seed | 16'h0C00;
        lp_word_valid = 1'b1;
        @(negedge clk);
        lp_word_valid = 1'b0;
        lp_word = ~lp_word;
        rd(5'h05, (seed | 16'h0C00) & 16'hEDFF);
        wr(5'h00, 16'h1000);
        wr(5'h04, 16'h0DE1);
        rd(5'h04, 16'h0DE1);
        `CHK(pause_sym_en, 1'b1)
        `CHK(pause_asym_en, 1'b0)
        wr(5'h04, 16'h09E1);
        `CHK(pause_sym_en, 1'b0)
        `CHK(pause_asym_en, 1'b1)
        wr(5'h02, 16'h0F0F);
        rd(5'h02, 16'h0F0F);
        wr(5'h03, 16'hF0F0);
        rd(5'h03, 16'hF0F0);
        // Soft reset restores the control, identifier high, advertisement and partner fields
        wr(5'h00, 16'h4180);
        wr(5'h00, 16'h8000);
        rd(5'h00, 16'h3000);
        rd(5'h02, ID_H);
        rd(5'h04, 16'h01E1);
        rd(5'h05, 16'h0000);
        `CHK(loopback_en, 1'b0)
        `CHK(chk_q.size(), 0)
        conclude();
    end
endmodule
